// ==== txh_engine_model.sv ====
`timescale 1ns/1ps
module txh_engine_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [1:0] i_mode,
    input wire logic i_valid,
    input wire logic i_eom,
    output logic o_ready,
    output logic o_done
);
    // mode 0 takes a byte every cycle, 1 every other cycle, 2 holds off
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ready <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && !o_ready);
            // message ends once the byte carrying the end mark is taken
            o_done <= i_valid && o_ready && i_eom;
        end
    end
endmodule

// ==== txh_fifo_status.sv ====
`timescale 1ns/1ps
// What this block does
// - two-bit watermark select: 4/16/32/48 bytes
// - below-watermark flag live while level below watermark
// - live not-full flag at bit 0
// - live full flag at bit 2
// - live empty flag at bit 3
// - latch not-full event on not-full rising edge
// - latch below-watermark event on its rising edge
// - latch message-end event when engine finishes message
// - latch underrun on empty mid-message, then abort
// - latched bits stay until cleared, re-set on new event
// - write ones clear latched bits, zeros keep them
// - status writes never touch live bits
// - unmasked latched event pulls interrupt low
// - interrupt released when no unmasked event pending
// - eight port copies, stride 0x200
// - abort is FEh, then flag or idle fill
module txh_fifo_status (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire txh_pkg::txh_axi_req_t i_axi,
    output txh_pkg::txh_axi_rsp_t o_axi,
    input wire logic [txh_pkg::TXH_PORTS-1:0] i_tx_ready,
    input wire logic [txh_pkg::TXH_PORTS-1:0] i_msg_done,
    output txh_pkg::txh_tx_t o_tx,
    output logic o_int_n
);
    import txh_pkg::*;

    txh_st_t st_ff;
    txh_st_t nxt_st;
    logic wr_fire;
    logic wr_en;
    logic [11:0] wr_idx;
    logic [11:0] rd_idx;
    logic [2:0] rd_port;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic [TXH_PORTS-1:0] nf_v;
    logic [TXH_PORTS-1:0] full_v;
    logic [TXH_PORTS-1:0] empty_v;
    logic [TXH_PORTS-1:0] bw_v;
    logic [TXH_PORTS-1:0] udr_v;
    logic [TXH_PORTS-1:0] irq_v;
    logic [TXH_PORTS-1:0][6:0] lvl_v;
    logic [TXH_PORTS-1:0][3:0] clr_v;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    assign wr_en = wr_fire && st_ff.wstrb[0];
    // only the low byte lane carries a register; other lanes are ignored
    assign wr_idx = st_ff.awaddr[TXH_AW-1:2];
    assign wr_byte = st_ff.wdata[7:0];
    assign rd_idx = i_axi.araddr[TXH_AW-1:2];
    assign rd_port = rd_idx[11:9];

    // readies are held low while frozen so no handshake is lost
    assign o_axi.awready = i_ce && !st_ff.aw_got && !st_ff.bvalid;
    assign o_axi.wready = i_ce && !st_ff.w_got && !st_ff.bvalid;
    assign o_axi.bvalid = st_ff.bvalid;
    assign o_axi.bresp = st_ff.bresp;
    assign o_axi.arready = i_ce && !st_ff.rvalid;
    assign o_axi.rvalid = st_ff.rvalid;
    assign o_axi.rdata = st_ff.rdata;
    assign o_axi.rresp = st_ff.rresp;
    assign o_int_n = ~(|irq_v);

    for (genvar g = 0; g < TXH_PORTS; g++) begin : g_port
        assign lvl_v[g] = st_ff.p[g].wptr - st_ff.p[g].rptr;
        assign empty_v[g] = (lvl_v[g] == '0);
        assign full_v[g] = (lvl_v[g] == TXH_DEPTH_CNT);
        assign nf_v[g] = !full_v[g];
        assign bw_v[g] = lvl_v[g] < TXH_WM_BYTES[st_ff.p[g].wm_sel];
        // engine wants a byte mid-message and nothing is left
        assign udr_v[g] = i_tx_ready[g] && !st_ff.p[g].out_valid && empty_v[g]
                          && (st_ff.p[g].tx == TXS_MSG);
        assign clr_v[g] = (wr_en && wr_idx == {3'(g), IDX_EVENT_LATCH}) ? wr_byte[3:0] : 4'h0;
        assign irq_v[g] = |(st_ff.p[g].lat & st_ff.p[g].mask);
        assign o_tx.valid[g] = i_ce && st_ff.p[g].out_valid;
        assign o_tx.eom[g] = st_ff.p[g].out_eom;
        assign o_tx.data[g] = st_ff.p[g].out_byte;

        AST_NF_SET: assert property (i_ce && nf_v[g] && st_ff.p[g].prev_full |=> st_ff.p[g].lat[EV_NF])
            else $error("not-full event missed");
        AST_BW_SET: assert property (i_ce && bw_v[g] && st_ff.p[g].prev_above ##1 1'b1 |-> st_ff.p[g].lat[EV_BW])
            else $error("below-watermark event missed");
        AST_MEND_SET: assert property (i_ce && i_msg_done[g] |=> st_ff.p[g].lat[EV_MEND])
            else $error("message-end event missed");
        AST_UDR_ABORT: assert property (i_ce && udr_v[g] |=> st_ff.p[g].lat[EV_UDR] && st_ff.p[g].out_valid
                && st_ff.p[g].out_byte == TXH_ABORT_BYTE && st_ff.p[g].tx == TXS_FILL)
            else $error("underrun did not latch and abort");
        AST_LAT_HOLD: assert property (i_ce |=> ((($past(st_ff.p[g].lat) & ~$past(clr_v[g])) & ~st_ff.p[g].lat)
                == 4'h0))
            else $error("latched bit dropped without clear");
        AST_W1C_CLEAR: assert property (i_ce && clr_v[g][EV_MEND] && !i_msg_done[g]
                |=> !st_ff.p[g].lat[EV_MEND])
            else $error("write-one did not clear");
        AST_LIVE_FLAGS: assert property ((empty_v[g] == (st_ff.p[g].wptr == st_ff.p[g].rptr))
                && (nf_v[g] != full_v[g]) && !(full_v[g] && empty_v[g]))
            else $error("live flags inconsistent");
        AST_WM_TOP: assert property (st_ff.p[g].wm_sel == 2'h3 && lvl_v[g] == 7'h2F |-> bw_v[g])
            else $error("watermark 48 not applied");
        AST_LIVE_RO: assert property (i_ce && wr_en && wr_idx == {3'(g), IDX_LIVE} && !i_tx_ready[g]
                && st_ff.p[g].out_valid |=> $stable(st_ff.p[g].wptr) && $stable(st_ff.p[g].rptr))
            else $error("live register write changed fifo");
    end

    AST_INT_SET: assert property (i_ce && i_msg_done[0] && st_ff.p[0].mask[EV_MEND] |=> !o_int_n)
        else $error("interrupt not asserted");
    AST_INT_RELEASE: assert property (irq_v == '0 |-> o_int_n)
        else $error("interrupt held without cause");

    always_comb begin
        nxt_st = st_ff;
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        case (rd_idx[8:0])
            IDX_WM_CTRL: rd_byte[1:0] = st_ff.p[rd_port].wm_sel;
            IDX_HDLC_CTRL: begin
                rd_byte[CTRL_EOM_BIT] = st_ff.p[rd_port].eom_arm;
                rd_byte[CTRL_FILL_BIT] = st_ff.p[rd_port].fill_sel;
            end
            IDX_EVENT_LATCH: rd_byte[3:0] = st_ff.p[rd_port].lat;
            IDX_EVENT_MASK: rd_byte[3:0] = st_ff.p[rd_port].mask;
            IDX_LIVE: begin
                rd_byte[LIVE_NF] = nf_v[rd_port];
                rd_byte[LIVE_BW] = bw_v[rd_port];
                rd_byte[LIVE_FULL] = full_v[rd_port];
                rd_byte[LIVE_EMPTY] = empty_v[rd_port];
            end
            IDX_AVAIL: rd_byte[6:0] = TXH_DEPTH_CNT - lvl_v[rd_port];
            IDX_DATA: rd_byte = 8'h00;
            default: rd_hit = 1'b0;
        endcase
        if (i_axi.arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = {24'h000000, rd_byte};
            nxt_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (st_ff.rvalid && i_axi.rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (i_axi.awvalid && !st_ff.aw_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = i_axi.awaddr;
        end
        if (i_axi.wvalid && !st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = i_axi.wdata;
            nxt_st.wstrb = i_axi.wstrb;
        end
        if (wr_fire) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            case (wr_idx[8:0])
                IDX_WM_CTRL, IDX_HDLC_CTRL, IDX_EVENT_LATCH, IDX_EVENT_MASK,
                IDX_LIVE, IDX_AVAIL, IDX_DATA: nxt_st.bresp = RESP_OKAY;
                default: nxt_st.bresp = RESP_SLVERR;
            endcase
        end else if (st_ff.bvalid && i_axi.bready) begin
            nxt_st.bvalid = 1'b0;
        end
        for (int k = 0; k < TXH_PORTS; k++) begin
            // one-byte output slot toward the bit engine
            if (st_ff.p[k].out_valid && i_tx_ready[k]) begin
                nxt_st.p[k].out_valid = 1'b0;
            end
            if (udr_v[k]) begin
                nxt_st.p[k].tx = TXS_FILL;
                nxt_st.p[k].out_valid = 1'b1;
                nxt_st.p[k].out_byte = TXH_ABORT_BYTE;
                nxt_st.p[k].out_eom = 1'b0;
            end else if ((!st_ff.p[k].out_valid || i_tx_ready[k]) && !empty_v[k]) begin
                {nxt_st.p[k].out_eom, nxt_st.p[k].out_byte} = st_ff.p[k].mem[st_ff.p[k].rptr[5:0]];
                nxt_st.p[k].out_valid = 1'b1;
                nxt_st.p[k].rptr = st_ff.p[k].rptr + TXH_PTR_STEP;
                nxt_st.p[k].tx = st_ff.p[k].mem[st_ff.p[k].rptr[5:0]][8] ? TXS_IDLE : TXS_MSG;
            end else if ((!st_ff.p[k].out_valid || i_tx_ready[k]) && st_ff.p[k].tx == TXS_FILL) begin
                // fill after an abort lasts until a new packet is queued
                nxt_st.p[k].out_valid = 1'b1;
                nxt_st.p[k].out_byte = st_ff.p[k].fill_sel ? TXH_IDLE_BYTE : TXH_FLAG_BYTE;
                nxt_st.p[k].out_eom = 1'b0;
            end
            if (wr_en && wr_idx[11:9] == 3'(k)) begin
                case (wr_idx[8:0])
                    IDX_DATA: begin
                        // a byte written while full is dropped; software polls the available count
                        if (!full_v[k]) begin
                            nxt_st.p[k].mem[st_ff.p[k].wptr[5:0]] = {st_ff.p[k].eom_arm, wr_byte};
                            nxt_st.p[k].wptr = st_ff.p[k].wptr + TXH_PTR_STEP;
                            nxt_st.p[k].eom_arm = 1'b0;
                        end
                    end
                    IDX_WM_CTRL: nxt_st.p[k].wm_sel = wr_byte[1:0];
                    IDX_HDLC_CTRL: begin
                        nxt_st.p[k].eom_arm = wr_byte[CTRL_EOM_BIT];
                        nxt_st.p[k].fill_sel = wr_byte[CTRL_FILL_BIT];
                    end
                    IDX_EVENT_MASK: nxt_st.p[k].mask = wr_byte[3:0];
                    IDX_EVENT_LATCH: nxt_st.p[k].lat = st_ff.p[k].lat & ~wr_byte[3:0];
                    default: nxt_st.p[k].lat = nxt_st.p[k].lat;
                endcase
            end
            // sets come after the clear so a coincident event is kept
            if (nf_v[k] && st_ff.p[k].prev_full) begin
                nxt_st.p[k].lat[EV_NF] = 1'b1;
            end
            if (bw_v[k] && st_ff.p[k].prev_above) begin
                nxt_st.p[k].lat[EV_BW] = 1'b1;
            end
            if (i_msg_done[k]) begin
                nxt_st.p[k].lat[EV_MEND] = 1'b1;
            end
            if (udr_v[k]) begin
                nxt_st.p[k].lat[EV_UDR] = 1'b1;
            end
            nxt_st.p[k].prev_full = full_v[k];
            nxt_st.p[k].prev_above = !bw_v[k];
        end
    end

    // empty fifo at reset: previous state "not full" and "below" gives no spurious event
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end
endmodule

// ==== txh_fifo_status_tb_top.sv ====
`timescale 1ns/1ps
module txh_fifo_status_tb_top;
    import txh_pkg::*;
    logic i_clk;
    logic i_rstn;
    txh_axi_req_t rq;
    txh_axi_rsp_t rs;
    txh_axi_rsp_t s;
    txh_tx_t tx;
    logic [7:1] rdy;
    logic e_rdy;
    logic e_done;
    logic [1:0] e_mode;
    logic int_n;
    logic [1:0] lr;
    logic [7:0] got[$];
    int num_errors;
    int n_checks;

    txh_fifo_status i_txh_fifo_status (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_axi(rq), .o_axi(rs),
        .i_tx_ready({rdy, e_rdy}), .i_msg_done({7'h00, e_done}), .o_tx(tx), .o_int_n(int_n));
    txh_engine_model i_txh_engine_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_mode(e_mode),
        .i_valid(tx.valid[0]), .i_eom(tx.eom[0]), .o_ready(e_rdy), .o_done(e_done));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        if (tx.valid[0] && e_rdy) got.push_back(tx.data[0]);
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic to_chk(input int t);
        if (t >= 200) begin
            num_errors++;
            $display("wait limit ran out");
            end_sim();
        end
    endtask

    function automatic logic [13:0] ad(input int p, input logic [8:0] idx);
        return 14'(4 * (int'(idx) + 'h200 * p));
    endfunction

    // requests change after a rising edge; ready is looked at mid-cycle, where it is settled
    task automatic wr(input int p, input logic [8:0] idx, input logic [7:0] d);
        logic aw;
        logic w;
        int t;
        aw = 1'b1;
        w = 1'b1;
        t = 0;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.awaddr <= ad(p, idx);
        rq.wdata <= {24'h000000, d};
        rq.wstrb <= 4'hF;
        rq.bready <= 1'b1;
        do begin
            @(negedge i_clk);
            s = rs;
            @(posedge i_clk);
            t++;
            if (aw && s.awready) rq.awvalid <= 1'b0;
            if (w && s.wready) rq.wvalid <= 1'b0;
            aw = aw && !s.awready;
            w = w && !s.wready;
        end while ((aw || w || !s.bvalid) && t < 200);
        // bready stays up between writes so back-to-back calls never drive it twice in one step
        to_chk(t);
        lr = s.bresp;
    endtask

    task automatic rck(input string nm, input int p, input logic [8:0] idx, input logic [7:0] e);
        int t;
        t = 0;
        rq.arvalid <= 1'b1;
        rq.araddr <= ad(p, idx);
        rq.rready <= 1'b1;
        do begin
            @(negedge i_clk);
            s = rs;
            @(posedge i_clk);
            t++;
            if (s.arready) rq.arvalid <= 1'b0;
        end while (!s.rvalid && t < 200);
        to_chk(t);
        lr = s.rresp;
        chk(nm, s.rdata, {24'h000000, e});
    endtask

    task automatic ick(input string nm, input logic e);
        @(negedge i_clk);
        chk(nm, int_n, e);
        @(posedge i_clk);
    endtask

    task automatic t_reset();
        rck("live_rst", 0, IDX_LIVE, 8'h0B);
        rck("latch_rst", 0, IDX_EVENT_LATCH, 8'h00);
        chk("irq_rst", int_n, 1'b1);
        wr(7, IDX_WM_CTRL, 8'h03);
        rck("wm_p7", 7, IDX_WM_CTRL, 8'h03);
        rck("wm_p0", 0, IDX_WM_CTRL, 8'h00);
        wr(0, IDX_LIVE, 8'hFF);
        rck("live_wr", 0, IDX_LIVE, 8'h0B);
        rck("unmapped", 0, 9'h100, 8'h00);
        chk("slverr", lr, RESP_SLVERR);
        $display("test reset done");
    endtask

    // port 1 engine stalls, so the first byte sits in the output slot outside the fifo
    task automatic t_fill();
        logic [6:0] lv;
        for (int n = 1; n <= 66; n++) begin
            wr(1, IDX_DATA, 8'(n));
            lv = (n > 65) ? 7'h40 : 7'(n - 1);
            for (int c = 0; c < 4; c++) begin
                wr(1, IDX_WM_CTRL, 8'(c));
                rck("live_fill", 1, IDX_LIVE, {4'h0, lv == 7'h00, lv == 7'h40, lv < TXH_WM_BYTES[c],
                    lv != 7'h40});
            end
        end
        wr(1, IDX_EVENT_LATCH, 8'h0F);
        rck("lat_clr", 1, IDX_EVENT_LATCH, 8'h00);
        rdy[1] <= 1'b1;
        @(posedge i_clk);
        rdy[1] <= 1'b0;
        // the event latches one edge after the pop, so let that edge pass before reading
        @(posedge i_clk);
        rck("lat_nf", 1, IDX_EVENT_LATCH, 8'h01);
        rdy[1] <= 1'b1;
        // two bytes drain per read; eight reads keep the level at or above the 48-byte mark
        for (int i = 0; i < 8; i++) rck("live_hi", 1, IDX_LIVE, 8'h01);
        for (int i = 0; i < 200; i++) begin
            @(posedge i_clk);
        end
        rck("lat_drain", 1, IDX_EVENT_LATCH, 8'h0B);
        wr(1, IDX_EVENT_LATCH, 8'h01);
        rck("lat_part", 1, IDX_EVENT_LATCH, 8'h0A);
        wr(1, IDX_EVENT_LATCH, 8'h0A);
        rck("lat_gone", 1, IDX_EVENT_LATCH, 8'h00);
        $display("test fill done");
    endtask

    task automatic t_msg();
        logic [7:0] ex [5] = '{8'hA5, 8'h11, 8'h22, TXH_ABORT_BYTE, TXH_IDLE_BYTE};
        int t;
        wr(0, IDX_EVENT_MASK, 8'h04);
        wr(0, IDX_HDLC_CTRL, 8'h04);
        wr(0, IDX_DATA, 8'hA5);
        t = 0;
        while (int_n !== 1'b0 && t < 200) begin
            @(posedge i_clk);
            t++;
        end
        to_chk(t);
        ick("irq_mend", 1'b0);
        rck("lat_mend", 0, IDX_EVENT_LATCH, 8'h04);
        wr(0, IDX_EVENT_LATCH, 8'h04);
        ick("irq_off", 1'b1);
        e_mode <= 2'h2;
        wr(0, IDX_EVENT_MASK, 8'h00);
        wr(0, IDX_HDLC_CTRL, 8'h08);
        wr(0, IDX_DATA, 8'h11);
        wr(0, IDX_DATA, 8'h22);
        e_mode <= 2'h1;
        t = 0;
        while (got.size() < 5 && t < 200) begin
            @(posedge i_clk);
            t++;
        end
        to_chk(t);
        for (int i = 0; i < 5; i++) chk("byte_out", got[i], ex[i]);
        rck("lat_udr", 0, IDX_EVENT_LATCH, 8'h08);
        ick("irq_masked", 1'b1);
        wr(0, IDX_EVENT_MASK, 8'h08);
        ick("irq_udr", 1'b0);
        wr(0, IDX_EVENT_LATCH, 8'h08);
        ick("irq_clr", 1'b1);
        $display("test message done");
    endtask

    initial begin
        i_rstn = 1'b0;
        rq = '0;
        rdy = 7'h00;
        e_mode = 2'h0;
        num_errors = 0;
        n_checks = 0;
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_fill();
        t_msg();
        end_sim();
    end
endmodule

// ==== txh_pkg.sv ====
package txh_pkg;
    localparam int TXH_PORTS = 8;
    localparam int TXH_AW = 14;
    localparam logic [6:0] TXH_DEPTH_CNT = 7'h40;
    localparam logic [6:0] TXH_PTR_STEP = 7'h01;
    // register indices; byte address = 4 * (index + port * 0x200)
    localparam logic [8:0] IDX_HDLC_CTRL = 9'h110;
    localparam logic [8:0] IDX_WM_CTRL = 9'h187;
    localparam logic [8:0] IDX_EVENT_LATCH = 9'h191;
    localparam logic [8:0] IDX_EVENT_MASK = 9'h1A1;
    localparam logic [8:0] IDX_LIVE = 9'h1B1;
    localparam logic [8:0] IDX_AVAIL = 9'h1B3;
    localparam logic [8:0] IDX_DATA = 9'h1B4;
    localparam int CTRL_EOM_BIT = 2;
    localparam int CTRL_FILL_BIT = 3;
    localparam int EV_NF = 0;
    localparam int EV_BW = 1;
    localparam int EV_MEND = 2;
    localparam int EV_UDR = 3;
    localparam int LIVE_NF = 0;
    localparam int LIVE_BW = 1;
    localparam int LIVE_FULL = 2;
    localparam int LIVE_EMPTY = 3;
    // watermark in bytes per select code 0..3
    localparam logic [3:0][6:0] TXH_WM_BYTES = {7'h30, 7'h20, 7'h10, 7'h04};
    localparam logic [7:0] TXH_ABORT_BYTE = 8'hFE;
    localparam logic [7:0] TXH_FLAG_BYTE = 8'h7E;
    localparam logic [7:0] TXH_IDLE_BYTE = 8'hFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {TXS_IDLE, TXS_MSG, TXS_FILL} txh_tx_state_t;

    typedef struct packed {
        logic awvalid;
        logic [TXH_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [TXH_AW-1:0] araddr;
        logic rready;
    } txh_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } txh_axi_rsp_t;

    typedef struct packed {
        logic [TXH_PORTS-1:0] valid;
        logic [TXH_PORTS-1:0] eom;
        logic [TXH_PORTS-1:0][7:0] data;
    } txh_tx_t;

    typedef struct packed {
        logic [1:0] wm_sel;
        logic fill_sel;
        logic eom_arm;
        logic [3:0] mask;
        logic [3:0] lat;
        logic prev_full;
        logic prev_above;
        txh_tx_state_t tx;
        logic [6:0] wptr;
        logic [6:0] rptr;
        logic [63:0][8:0] mem;
        logic out_valid;
        logic out_eom;
        logic [7:0] out_byte;
    } txh_port_t;

    typedef struct packed {
        logic aw_got;
        logic [TXH_AW-1:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        txh_port_t [TXH_PORTS-1:0] p;
    } txh_st_t;
endpackage
